/* rtl/uart_line_control_status.sv */
module uart_line_control_status #(
	parameter int depth = uart_lcs_pkg::fifo_depth
) (
	// APB slave.
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial and modem pins.
	input  wire logic        rx_in,
	output logic             tx_out,
	output logic             dtr_n,
	output logic             rts_n,
	output logic             irq_out,
	output logic             first_user_output,
	output logic             second_user_output,
	output logic             ring_indicator_input
);
	localparam int aw = $clog2(depth);

	logic [7:0]  lfc_q;
	logic [7:0]  moc_q;
	logic [3:0]  ier_q;
	logic        fifo_en_q;
	logic [15:0] div_q;
	logic [15:0] baud_cnt_q;
	logic        tick;

	logic        wr;
	logic        rd;
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & penable & ~pwrite;
	assign pready  = 1'b1;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	logic dlab;
	assign dlab = lfc_q[uart_lcs_pkg::lfc_dlab_bit];
	logic data_wr;
	logic data_rd;
	logic ls_rd;
	assign data_wr = wr & hit(paddr, uart_lcs_pkg::off_data) & ~dlab;
	assign data_rd = rd & hit(paddr, uart_lcs_pkg::off_data) & ~dlab;
	assign ls_rd   = rd & hit(paddr, uart_lcs_pkg::off_ls);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfc_q     <= uart_lcs_pkg::lfc_reset;
			moc_q     <= uart_lcs_pkg::moc_reset;
			ier_q     <= 4'h0;
			fifo_en_q <= 1'b0;
			div_q     <= uart_lcs_pkg::div_reset;
		end else if (wr) begin
			if (hit(paddr, uart_lcs_pkg::off_lfc)) begin
				lfc_q <= pwdata[7:0];
			end else if (hit(paddr, uart_lcs_pkg::off_moc)) begin
				moc_q <= {3'h0, pwdata[4:0]};
			end else if (hit(paddr, uart_lcs_pkg::off_fifo_ctl)) begin
				fifo_en_q <= pwdata[0];
			end else if (hit(paddr, uart_lcs_pkg::off_data) && dlab) begin
				div_q[7:0] <= pwdata[7:0];
			end else if (hit(paddr, uart_lcs_pkg::off_ier) && dlab) begin
				div_q[15:8] <= pwdata[7:0];
			end else if (hit(paddr, uart_lcs_pkg::off_ier)) begin
				ier_q <= pwdata[3:0];
			end
		end
	end

	// Sixteen ticks per bit time; the half-stop case needs the finer grain.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt_q <= 16'h0000;
		end else if (baud_cnt_q >= div_q - 16'h0001) begin
			baud_cnt_q <= 16'h0000;
		end else begin
			baud_cnt_q <= baud_cnt_q + 16'h0001;
		end
	end
	assign tick = (baud_cnt_q >= div_q - 16'h0001);

	logic [3:0] nbits;
	assign nbits = 4'd5 + {2'b00, lfc_q[1:0]};
	// Stop length in sixteenths of a bit.
	logic [5:0] stop16;
	assign stop16 = !lfc_q[2] ? 6'd16 : (lfc_q[1:0] == 2'b00 ? 6'd24 : 6'd32);

	function automatic logic par_of(input logic [7:0] d, input logic [3:0] n, input logic [7:0] f);
		logic [7:0] m;
		m = d & ~(8'hff << n);
		if (f[5]) begin
			par_of = ~f[4];
		end else begin
			par_of = (^m) ^ ~f[4];
		end
	endfunction

	// Transmit side.
	logic [7:0]  tx_mem [depth];
	logic [aw:0] tx_cnt_q;
	logic [aw-1:0] tx_wp_q;
	logic [aw-1:0] tx_rp_q;
	uart_lcs_pkg::tx_state_e tx_st_q;
	logic [11:0] tx_sh_q;
	logic [3:0]  tx_left_q;
	logic [3:0]  tx_sub_q;
	logic [5:0]  tx_stop_q;
	logic        tx_line_q;
	logic        tx_load;
	logic [aw:0] tx_cap;
	assign tx_cap  = fifo_en_q ? (aw+1)'(depth) : (aw+1)'(1);
	assign tx_load = (tx_st_q == uart_lcs_pkg::tx_idle) && (tx_cnt_q != '0) && tick;

	always_ff @(posedge pclk) begin
		if (data_wr && tx_cnt_q < tx_cap) begin
			tx_mem[tx_wp_q] <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_cnt_q <= '0;
			tx_wp_q  <= '0;
			tx_rp_q  <= '0;
		end else begin
			if (data_wr && tx_cnt_q < tx_cap) begin
				tx_wp_q <= tx_wp_q + 1'b1;
			end
			if (tx_load) begin
				tx_rp_q <= tx_rp_q + 1'b1;
			end
			tx_cnt_q <= tx_cnt_q + (aw+1)'(data_wr && tx_cnt_q < tx_cap) - (aw+1)'(tx_load);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q   <= uart_lcs_pkg::tx_idle;
			tx_sh_q   <= 12'hfff;
			tx_left_q <= 4'h0;
			tx_sub_q  <= 4'h0;
			tx_stop_q <= 6'd0;
			tx_line_q <= 1'b1;
		end else begin
			case (tx_st_q)
				uart_lcs_pkg::tx_idle: begin
					tx_line_q <= 1'b1;
					if (tx_load) begin
						// Start, data, optional parity; stop handled by its own count.
						tx_sh_q   <= {2'b11, tx_mem[tx_rp_q], 1'b0, 1'b0} >> 1;
						if (lfc_q[3]) begin
							tx_sh_q[4'd1 + nbits] <= par_of(tx_mem[tx_rp_q], nbits, lfc_q);
						end
						tx_left_q <= 4'd1 + nbits + {3'b000, lfc_q[3]};
						tx_sub_q  <= 4'h0;
						tx_stop_q <= stop16;
						tx_st_q   <= uart_lcs_pkg::tx_shift;
					end
				end
				uart_lcs_pkg::tx_shift: begin
					if (tick) begin
						if (tx_left_q != 4'h0) begin
							tx_line_q <= tx_sh_q[0];
							tx_sub_q  <= tx_sub_q + 4'h1;
							if (tx_sub_q == 4'hf) begin
								tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
								tx_left_q <= tx_left_q - 4'h1;
							end
						end else begin
							tx_line_q <= 1'b1;
							tx_stop_q <= tx_stop_q - 6'd1;
							if (tx_stop_q == 6'd1) begin
								tx_st_q <= uart_lcs_pkg::tx_idle;
							end
						end
					end
				end
				default: tx_st_q <= uart_lcs_pkg::tx_idle;
			endcase
		end
	end

	logic lb;
	logic tx_bit;
	assign lb     = moc_q[uart_lcs_pkg::moc_lb_bit];
	assign tx_bit = tx_line_q & ~lfc_q[uart_lcs_pkg::lfc_brk_bit];

	// Receive side.
	logic rx_src;
	assign rx_src = lb ? tx_bit : rx_in;
	uart_lcs_pkg::rx_entry_s rx_mem [depth];
	logic [aw:0]   rx_cnt_q;
	logic [aw-1:0] rx_wp_q;
	logic [aw-1:0] rx_rp_q;
	logic [aw:0]   rx_err_cnt_q;
	uart_lcs_pkg::rx_state_e rx_st_q;
	logic [3:0]  rx_sub_q;
	logic [3:0]  rx_idx_q;
	logic [9:0]  rx_sh_q;
	logic        rx_push;
	logic        rx_allbrk;
	logic        rx_frm;
	logic        rx_par;
	logic        overrun_q;
	logic        ls_pend_q;
	logic [aw:0] rx_cap;
	logic        rx_pop;
	uart_lcs_pkg::rx_entry_s rx_new;
	uart_lcs_pkg::rx_entry_s rx_head;
	assign rx_cap  = fifo_en_q ? (aw+1)'(depth) : (aw+1)'(1);
	assign rx_head = rx_mem[rx_rp_q];
	assign rx_pop  = data_rd && rx_cnt_q != '0;

	logic [3:0] rx_total;
	assign rx_total = 4'd1 + nbits + {3'b000, lfc_q[3]};
	logic       rx_done;
	assign rx_done = (rx_st_q == uart_lcs_pkg::rx_shift) && tick && rx_sub_q == 4'h7 && rx_idx_q == rx_total;
	assign rx_allbrk = ~rx_src && (rx_sh_q == 10'h000);
	assign rx_frm    = ~rx_src;
	assign rx_par    = lfc_q[3] && (rx_sh_q[nbits] != par_of(rx_sh_q[7:0], nbits, lfc_q));
	assign rx_push   = rx_done && rx_cnt_q < rx_cap;
	assign rx_new    = '{brk: rx_allbrk, frm: rx_frm & ~rx_allbrk, par: rx_par & ~rx_allbrk,
		data: rx_allbrk ? 8'h00 : rx_sh_q[7:0] & ~(8'hff << nbits)};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_q  <= uart_lcs_pkg::rx_idle;
			rx_sub_q <= 4'h0;
			rx_idx_q <= 4'h0;
			rx_sh_q  <= 10'h000;
		end else if (tick) begin
			case (rx_st_q)
				uart_lcs_pkg::rx_idle: begin
					rx_sub_q <= 4'h0;
					rx_idx_q <= 4'h0;
					if (!rx_src) begin
						rx_st_q <= uart_lcs_pkg::rx_shift;
					end
				end
				uart_lcs_pkg::rx_shift: begin
					rx_sub_q <= rx_sub_q + 4'h1;
					if (rx_sub_q == 4'h7) begin
						if (rx_idx_q == 4'h0 && rx_src) begin
							rx_st_q <= uart_lcs_pkg::rx_idle;
						end else if (rx_idx_q == rx_total) begin
							// One break character only, then wait for mark.
							rx_st_q <= rx_allbrk ? uart_lcs_pkg::rx_brkwait : uart_lcs_pkg::rx_idle;
						end else begin
							if (rx_idx_q != 4'h0) begin
								rx_sh_q[rx_idx_q - 4'h1] <= rx_src;
							end
							rx_idx_q <= rx_idx_q + 4'h1;
						end
					end
				end
				uart_lcs_pkg::rx_brkwait: begin
					if (rx_src) begin
						rx_st_q <= uart_lcs_pkg::rx_idle;
					end
				end
				default: rx_st_q <= uart_lcs_pkg::rx_idle;
			endcase
			if (rx_st_q == uart_lcs_pkg::rx_idle) begin
				rx_sh_q <= 10'h000;
			end
		end
	end

	always_ff @(posedge pclk) begin
		if (rx_push) begin
			rx_mem[rx_wp_q] <= rx_new;
		end
	end

	logic new_err;
	logic head_err;
	assign new_err  = rx_new.brk | rx_new.frm | rx_new.par;
	assign head_err = rx_head.brk | rx_head.frm | rx_head.par;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cnt_q     <= '0;
			rx_wp_q      <= '0;
			rx_rp_q      <= '0;
			rx_err_cnt_q <= '0;
		end else begin
			if (rx_push) begin
				rx_wp_q <= rx_wp_q + 1'b1;
			end
			if (rx_pop) begin
				rx_rp_q <= rx_rp_q + 1'b1;
			end
			rx_cnt_q     <= rx_cnt_q + (aw+1)'(rx_push) - (aw+1)'(rx_pop);
			rx_err_cnt_q <= rx_err_cnt_q + (aw+1)'(rx_push & new_err) - (aw+1)'(rx_pop & head_err);
		end
	end

	// Set wins over the clearing status read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_q <= 1'b0;
		end else if (rx_done && !rx_push) begin
			overrun_q <= 1'b1;
		end else if (ls_rd) begin
			overrun_q <= 1'b0;
		end
	end

	logic have_rx;
	logic head_tags;
	assign have_rx   = rx_cnt_q != '0;
	assign head_tags = have_rx & head_err;
	logic head_new_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			head_new_q <= 1'b0;
		end else begin
			head_new_q <= have_rx & ~rx_pop;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_pend_q <= 1'b0;
		end else if ((rx_done && !rx_push) || (head_new_q == 1'b0 && head_tags)) begin
			ls_pend_q <= 1'b1;
		end else if (ls_rd) begin
			ls_pend_q <= 1'b0;
		end
	end

	logic [7:0] ls_val;
	assign ls_val = {rx_err_cnt_q != '0 && fifo_en_q,
		tx_cnt_q == '0 && tx_st_q == uart_lcs_pkg::tx_idle,
		tx_cnt_q == '0,
		head_tags & rx_head.brk,
		head_tags & rx_head.frm,
		head_tags & rx_head.par,
		overrun_q,
		have_rx};

	logic irq_any;
	assign irq_any = ier_q[uart_lcs_pkg::ier_ls_bit] & ls_pend_q | ier_q[0] & have_rx | ier_q[1] & tx_cnt_q == '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (hit(paddr, uart_lcs_pkg::off_data)) begin
				prdata <= {24'h0, dlab ? div_q[7:0] : rx_head.data};
			end else if (hit(paddr, uart_lcs_pkg::off_ier)) begin
				prdata <= {24'h0, dlab ? div_q[15:8] : {4'h0, ier_q}};
			end else if (hit(paddr, uart_lcs_pkg::off_lfc)) begin
				prdata <= {24'h0, lfc_q};
			end else if (hit(paddr, uart_lcs_pkg::off_moc)) begin
				prdata <= {24'h0, moc_q};
			end else if (hit(paddr, uart_lcs_pkg::off_ls)) begin
				prdata <= {24'h0, ls_val};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	logic unmapped;
	assign unmapped = !(hit(paddr, uart_lcs_pkg::off_data) || hit(paddr, uart_lcs_pkg::off_ier) ||
		hit(paddr, uart_lcs_pkg::off_fifo_ctl) || hit(paddr, uart_lcs_pkg::off_lfc) ||
		hit(paddr, uart_lcs_pkg::off_moc) || hit(paddr, uart_lcs_pkg::off_ls));
	assign pslverr = psel & penable & unmapped;

	// Pin outputs; in loopback tx_out, dtr_n and rts_n rest inactive, first_user_output still follows moc_q[2], and the bits go inside.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_out               <= 1'b1;
			dtr_n                <= 1'b1;
			rts_n                <= 1'b1;
			irq_out              <= 1'b0;
			first_user_output    <= 1'b1;
			second_user_output   <= 1'b1;
			ring_indicator_input <= 1'b1;
		end else begin
			tx_out               <= lb ? 1'b1 : tx_bit;
			dtr_n                <= lb ? 1'b1 : ~moc_q[0];
			rts_n                <= lb ? 1'b1 : ~moc_q[1];
			irq_out              <= ~lb & moc_q[uart_lcs_pkg::moc_ien_bit] & irq_any;
			first_user_output    <= ~moc_q[2];
			second_user_output   <= ~(lb & moc_q[uart_lcs_pkg::moc_ien_bit]);
			ring_indicator_input <= lb ? ~moc_q[2] : 1'b1;
		end
	end
endmodule

/* rtl/uart_lcs_pkg.sv */
package uart_lcs_pkg;
	localparam logic [11:0] off_data     = 12'h000;
	localparam logic [11:0] off_ier      = 12'h004;
	localparam logic [11:0] off_fifo_ctl = 12'h008;
	localparam logic [11:0] off_lfc      = 12'h00c;
	localparam logic [11:0] off_moc      = 12'h010;
	localparam logic [11:0] off_ls       = 12'h014;
	localparam int          fifo_depth   = 128;
	localparam logic [7:0]  lfc_reset    = 8'h00;
	localparam logic [7:0]  moc_reset    = 8'h00;
	localparam logic [15:0] div_reset    = 16'h0001;
	localparam int          ier_ls_bit   = 2;
	localparam int          lfc_brk_bit  = 6;
	localparam int          lfc_dlab_bit = 7;
	localparam int          moc_lb_bit   = 4;
	localparam int          moc_ien_bit  = 3;
	typedef struct packed {
		logic       brk;
		logic       frm;
		logic       par;
		logic [7:0] data;
	} rx_entry_s;
	typedef enum logic [1:0] {
		tx_idle, tx_shift
	} tx_state_e;
	typedef enum logic [1:0] {
		rx_idle, rx_shift, rx_brkwait
	} rx_state_e;
endpackage

/* testbench/uart_lcs_chk.sv */
module uart_lcs_chk (
	// Clock, reset and bus.
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Pins.
	input wire logic        tx_out,
	input wire logic        dtr_n,
	input wire logic        rts_n,
	input wire logic        irq_out,
	input wire logic        second_user_output,
	input wire logic        ring_indicator_input
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lfc_q;
	logic [7:0] moc_q;
	logic       wr;
	assign wr = psel && penable && pwrite;
	// Shadow copies let the pins be judged once a write has had time to reach them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfc_q <= uart_lcs_pkg::lfc_reset;
			moc_q <= uart_lcs_pkg::moc_reset;
		end else if (wr && paddr == uart_lcs_pkg::off_lfc) begin
			lfc_q <= pwdata[7:0];
		end else if (wr && paddr == uart_lcs_pkg::off_moc) begin
			moc_q <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_quiet;
		(!wr)[*3];
	endsequence
	sequence s_loop;
		s_quiet ##0 moc_q[4];
	endsequence
	sequence s_norm;
		s_quiet ##0 !moc_q[4];
	endsequence
	a_break_hold: assert property (s_norm ##0 lfc_q[6] |-> !tx_out) else $error("tx not low in break");
	a_dtr_level: assert property (s_norm |-> dtr_n == !moc_q[0]) else $error("dtr level wrong");
	a_rts_level: assert property (s_norm |-> rts_n == !moc_q[1]) else $error("rts level wrong");
	a_irq_gate: assert property (s_quiet ##0 !moc_q[3] |-> !irq_out) else $error("irq not gated");
	a_loop_tx_idle: assert property (s_loop |-> tx_out && !irq_out) else $error("tx not idle in loop");
	a_loop_pins: assert property (s_loop |-> dtr_n && rts_n) else $error("modem pins low in loop");
	a_loop_ring: assert property (s_loop |-> ring_indicator_input == !moc_q[2]) else $error("ring wrong");
	a_loop_user2: assert property (s_loop |-> second_user_output == !moc_q[3]) else $error("user2 wrong");
endmodule

bind uart_line_control_status uart_lcs_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_out(tx_out), .dtr_n(dtr_n),
	.rts_n(rts_n), .irq_out(irq_out), .second_user_output(second_user_output),
	.ring_indicator_input(ring_indicator_input));

/* testbench/uart_far_end.sv */
module uart_far_end (
	// Clock.
	input  wire logic       pclk,
	// Serial lines and frame size.
	input  wire logic       tx_out,
	input  wire logic [3:0] nbits,
	output logic            rx_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] frame;
	int          got;
	int          gap;
	time         last;
	initial begin
		rx_in = 1'b1;
		got = 0;
		last = 0;
	end
	// Bit centres are sampled; the stop bit lands at index nbits.
	always begin
		@(negedge tx_out);
		gap = int'(($time - last) / 8);
		last = $time;
		frame = '1;
		repeat (8) @(posedge pclk);
		for (int i = 0; i <= nbits; i++) begin
			repeat (16) @(posedge pclk);
			frame[i] = tx_out;
		end
		got++;
	end
	task automatic send(input logic [19:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			rx_in <= f[i];
			repeat (15) @(posedge pclk);
		end
		@(posedge pclk);
		rx_in <= 1'b1;
	endtask
endmodule

/* testbench/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_in;
	logic        tx_out;
	logic        dtr_n;
	logic        rts_n;
	logic        irq_out;
	logic        first_user_output;
	logic        second_user_output;
	logic        ring_indicator_input;
	logic [3:0]  nbits;
	logic [31:0] rd;
	logic        err;
	logic [31:0] rng;
	logic [7:0]  d;
	int          fail_count;
	int          num_checks;
	int          cycles;
	int          g0;
	int          e;
	uart_line_control_status uart_line_control_status_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .dtr_n(dtr_n), .rts_n(rts_n), .irq_out(irq_out),
		.first_user_output(first_user_output), .second_user_output(second_user_output),
		.ring_indicator_input(ring_indicator_input));
	uart_far_end uart_far_end_i (.pclk(pclk), .tx_out(tx_out), .nbits(nbits), .rx_in(rx_in));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			fail_count++;
			summarize();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [11:0] tx_bits(input logic [7:0] c, input logic [7:0] v);
		int          n;
		logic [11:0] f;
		n = 5 + c[1:0];
		f = '1;
		for (int i = 0; i < n; i++) f[i] = v[i];
		if (c[3]) f[n] = c[5] ? !c[4] : ^(v & ~(8'hff << n)) ^ !c[4];
		return f;
	endfunction
	function automatic int tx_gap(input logic [7:0] c);
		int n;
		n = 5 + c[1:0];
		return 16 * (1 + n + c[3]) + (!c[2] ? 16 : (n == 5 ? 24 : 32));
	endfunction
	function automatic logic [19:0] rx_fr(input logic [7:0] v, input logic p, input logic s);
		return {9'h1ff, s, p, v, 1'b0};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task automatic wait_ls(input int b);
		for (int i = 0; i < 3000; i++) begin
			apb(1'b0, uart_lcs_pkg::off_ls, 32'h0);
			if (rd[b] === 1'b1) break;
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		nbits = 4'h5;
		fail_count = 0;
		num_checks = 0;
		cycles = 0;
		rng = 32'h0000cbe1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("lfc", uart_lcs_pkg::off_lfc, 32'h0);
		rdchk("moc", uart_lcs_pkg::off_moc, 32'h0);
		rdchk("ls", uart_lcs_pkg::off_ls, 32'h60);
		apb(1'b0, 12'h018, 32'h0);
		chk("unmapped", 32'h3, {30'h0, pready, err});
		apb(1'b1, uart_lcs_pkg::off_ier, 32'h5);
		apb(1'b1, uart_lcs_pkg::off_lfc, 32'h80);
		rdchk("div high", uart_lcs_pkg::off_ier, 32'h0);
		rdchk("div low", uart_lcs_pkg::off_data, 32'h1);
		apb(1'b1, uart_lcs_pkg::off_ier, 32'h5a);
		apb(1'b1, uart_lcs_pkg::off_data, 32'h01);
		rdchk("div set", uart_lcs_pkg::off_ier, 32'h5a);
		rdchk("no tx", uart_lcs_pkg::off_ls, 32'h60);
		apb(1'b1, uart_lcs_pkg::off_ier, 32'h0);
		apb(1'b1, uart_lcs_pkg::off_lfc, 32'h0);
		rdchk("ier", uart_lcs_pkg::off_ier, 32'h5);
		apb(1'b1, uart_lcs_pkg::off_ier, 32'h0);
		for (int c = 0; c < 64; c++) begin
			rng = xs(rng);
			nbits <= 4'(5 + c[1:0] + c[3]);
			apb(1'b1, uart_lcs_pkg::off_lfc, 32'(c));
			g0 = uart_far_end_i.got;
			apb(1'b1, uart_lcs_pkg::off_data, {24'h0, rng[7:0]});
			wait_ls(5);
			apb(1'b1, uart_lcs_pkg::off_data, {24'h0, rng[15:8]});
			rdchk("ls busy", uart_lcs_pkg::off_ls, 32'h0);
			wait_ls(6);
			e = tx_gap(8'(c));
			chk("frames", 32'(g0 + 2), 32'(uart_far_end_i.got));
			chk("frame", {20'h0, tx_bits(8'(c), rng[15:8])}, {20'h0, uart_far_end_i.frame});
			chk("gap", 32'h1, {31'h0, uart_far_end_i.gap >= e && uart_far_end_i.gap <= e + 2});
		end
		apb(1'b1, uart_lcs_pkg::off_moc, 32'h03);
		repeat (3) @(posedge pclk);
		chk("dtr rts", 32'h0, {30'h0, dtr_n, rts_n});
		apb(1'b1, uart_lcs_pkg::off_lfc, 32'h03);
		apb(1'b1, uart_lcs_pkg::off_moc, 32'h1c);
		g0 = uart_far_end_i.got;
		apb(1'b1, uart_lcs_pkg::off_data, 32'hc3);
		wait_ls(0);
		rdchk("loop data", uart_lcs_pkg::off_data, 32'hc3);
		chk("loop pins", 32'h70, {25'h0, tx_out, dtr_n, rts_n, irq_out, ring_indicator_input,
			second_user_output, first_user_output});
		chk("loop quiet", 32'(g0), 32'(uart_far_end_i.got));
		apb(1'b1, uart_lcs_pkg::off_ier, 32'h4);
		apb(1'b1, uart_lcs_pkg::off_moc, 32'h08);
		uart_far_end_i.send(rx_fr(8'h3c, 1'b1, 1'b1), 10);
		wait_ls(0);
		uart_far_end_i.send(rx_fr(8'ha5, 1'b1, 1'b1), 10);
		for (int i = 0; i < 300 && irq_out !== 1'b1; i++) @(posedge pclk);
		chk("overrun irq", 32'h1, {31'h0, irq_out});
		rdchk("overrun ls", uart_lcs_pkg::off_ls, 32'h63);
		repeat (2) @(posedge pclk);
		chk("irq clear", 32'h0, {31'h0, irq_out});
		rdchk("kept", uart_lcs_pkg::off_data, 32'h3c);
		rdchk("ls empty", uart_lcs_pkg::off_ls, 32'h60);
		apb(1'b1, uart_lcs_pkg::off_lfc, 32'h1b);
		for (int k = 0; k < 3; k++) begin
			rng = xs(rng);
			d = {rng[7:1], 1'b1};
			case (k)
				0: uart_far_end_i.send(rx_fr(d, ~^d, 1'b1), 11);
				1: uart_far_end_i.send(rx_fr(d, ^d, 1'b0), 11);
				default: uart_far_end_i.send(20'h0, 20);
			endcase
			chk("err irq", 32'h1, {31'h0, irq_out});
			wait_ls(0);
			chk("tags", k == 0 ? 32'h65 : (k == 1 ? 32'h69 : 32'h71), rd);
			rdchk("char", uart_lcs_pkg::off_data, k == 2 ? 32'h0 : {24'h0, d});
			rdchk("untagged", uart_lcs_pkg::off_ls, 32'h60);
		end
		apb(1'b1, uart_lcs_pkg::off_fifo_ctl, 32'h1);
		uart_far_end_i.send(rx_fr(8'h81, 1'b1, 1'b1), 11);
		uart_far_end_i.send(rx_fr(8'h42, 1'b0, 1'b1), 11);
		rdchk("fifo ls", uart_lcs_pkg::off_ls, 32'he5);
		rdchk("fifo head", uart_lcs_pkg::off_data, 32'h81);
		rdchk("fifo clean", uart_lcs_pkg::off_ls, 32'h61);
		apb(1'b1, uart_lcs_pkg::off_lfc, 32'h43);
		repeat (3) @(posedge pclk);
		chk("break", 32'h0, {31'h0, tx_out});
		apb(1'b1, uart_lcs_pkg::off_lfc, 32'h03);
		repeat (3) @(posedge pclk);
		chk("break end", 32'h1, {31'h0, tx_out});
		summarize();
	end
endmodule
